// file: test/tpls_checker.sv
// Concurrent checks on the ports of the touch probe latch unit.
`timescale 1ns/1ps
module tpls_checker
   import tpls_pkg::*;
#(
   parameter int POS_W = 32
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [15:0] probe_function_word,
   input wire logic [15:0] probe_status_word,
   input wire logic [POS_W-1:0] p1_pos_rise,
   input wire logic [POS_W-1:0] p1_pos_fall,
   input wire logic [POS_W-1:0] p2_pos_rise,
   input wire logic [POS_W-1:0] p2_pos_fall
);
   logic [2:0] up_q;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   // Three clean edges out of reset are needed before the status pipeline is valid.
   always_ff @(posedge ref_clk) begin
      up_q <= {up_q[1:0], reset_n};
   end
   AST_RSV: assert property (probe_status_word[7:3] == 5'h00 && probe_status_word[15:11] == 5'h00)
      else $error("reserved status bit set");
   // Running rises one edge later than it falls, because the start edge itself
   // clears the channel before it reports running.
   AST_RUN1: assert property (&up_q |-> probe_status_word[0] ==
         ($past(probe_function_word[0], 2) && $past(probe_function_word[0], 3)))
      else $error("probe 1 running bit wrong");
   AST_RUN2: assert property (&up_q |-> probe_status_word[8] ==
         ($past(probe_function_word[8], 2) && $past(probe_function_word[8], 3)))
      else $error("probe 2 running bit wrong");
   AST_CLR1: assert property (&up_q && !$past(probe_function_word[0], 3) |-> probe_status_word[2:1] == 2'h0)
      else $error("probe 1 flags not cleared");
   AST_CLR2: assert property (&up_q && !$past(probe_function_word[8], 3) |-> probe_status_word[10:9] == 2'h0)
      else $error("probe 2 flags not cleared");
   AST_FLG9: assert property (up_q[0] && $changed(p2_pos_rise) |=> probe_status_word[9])
      else $error("probe 2 rise flag missing");
   AST_FLF2: assert property (up_q[0] && $changed(p1_pos_fall) |=> probe_status_word[2])
      else $error("probe 1 fall flag missing");
   AST_CAP1: assert property (up_q[0] && $changed(p1_pos_rise) |=> probe_status_word[0])
      else $error("probe 1 captured while stopped");
   AST_FLR1: assert property (up_q[0] && $changed(p1_pos_rise) |=>
         probe_status_word[1])
      else $error("probe 1 rise flag missing");
   AST_FL10: assert property (up_q[0] && $changed(p2_pos_fall) |=>
         probe_status_word[10])
      else $error("probe 2 fall flag missing");
endmodule
bind tpls_top tpls_checker #(.POS_W(POS_W)) i_tpls_checker (
   .ref_clk(ref_clk), .reset_n(reset_n), .probe_function_word(probe_function_word),
   .probe_status_word(probe_status_word), .p1_pos_rise(p1_pos_rise),
   .p1_pos_fall(p1_pos_fall), .p2_pos_rise(p2_pos_rise),
   .p2_pos_fall(p2_pos_fall)
);

// file: test/tpls_master.sv
// Fieldbus master model that writes the probe function word.
`timescale 1ns/1ps
module tpls_master (
   input wire logic ref_clk,
   output logic [15:0] probe_function_word
);
   initial probe_function_word = 16'h0000;
   // Every start is a fresh 0-to-1 of execute, so new settings are taken; a falling enable set with the zero pulse source is dropped.
   task automatic start(input logic [15:0] w);
      if (w[2] && w[5]) w[5] = 1'b0;
      if (w[10] && w[13]) w[13] = 1'b0;
      @(negedge ref_clk) probe_function_word = w & 16'hFEFE;
      @(negedge ref_clk) probe_function_word = w;
   endtask
endmodule

// file: test/tpls_top_tb.sv
// Self-checking testbench for the touch probe latch unit.
`timescale 1ns/1ps
module tpls_top_tb
   import tpls_pkg::*;
;
   logic ref_clk, reset_n, probe1_in, probe2_in, enc_zero_in;
   logic [15:0] probe_function_word, probe_status_word;
   logic [31:0] position, p1_pos_rise, p1_pos_fall, p2_pos_rise, p2_pos_fall;
   int checks = 0;
   int mismatches = 0;
   tpls_master i_tpls_master (.ref_clk(ref_clk), .probe_function_word(probe_function_word));
   tpls_top i_tpls_top (
      .ref_clk(ref_clk), .reset_n(reset_n), .probe_function_word(probe_function_word),
      .probe1_in(probe1_in), .probe2_in(probe2_in), .enc_zero_in(enc_zero_in),
      .position(position), .probe_status_word(probe_status_word),
      .p1_pos_rise(p1_pos_rise), .p1_pos_fall(p1_pos_fall),
      .p2_pos_rise(p2_pos_rise), .p2_pos_fall(p2_pos_fall)
   );
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // ==========================================================================
   // Tasks
   // ==========================================================================
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic go(input logic [15:0] w);
      i_tpls_master.start(w);
      repeat (4) @(negedge ref_clk);
   endtask
   // The position is held across the whole capture so the latched value is exact.
   task automatic ev(input int pin, input logic lvl, input logic [31:0] pos);
      @(negedge ref_clk);
      position = pos;
      if (pin == 1) probe1_in = lvl;
      else if (pin == 2) probe2_in = lvl;
      else enc_zero_in = lvl;
      repeat (6) @(negedge ref_clk);
   endtask
   // ==========================================================================
   // Tests
   // ==========================================================================
   initial begin
      repeat (3000) @(posedge ref_clk);
      mismatches++;
      summarize();
   end
   initial begin
      reset_n = 1'b0;
      probe1_in = 1'b0;
      probe2_in = 1'b0;
      enc_zero_in = 1'b0;
      position = 32'h0000_0000;
      repeat (5) @(negedge ref_clk);
      reset_n = 1'b1;
      @(negedge ref_clk);
      chk(probe_status_word, TPLS_STATUS_RESET);
      chk(p1_pos_rise, TPLS_POS_RESET);
      $display("test reset done");
      go(16'h0031);
      chk(probe_status_word, 16'h0001);
      ev(1, 1'b1, 32'h0000_1111);
      chk(p1_pos_rise, 32'h0000_1111);
      ev(1, 1'b0, 32'h0000_2222);
      chk(p1_pos_fall, 32'h0000_2222);
      chk(probe_status_word, 16'h0007);
      ev(1, 1'b1, 32'h0000_3333);
      ev(1, 1'b0, 32'h0000_4444);
      chk(p1_pos_rise, 32'h0000_1111);
      chk(p1_pos_fall, 32'h0000_2222);
      $display("test probe 1 single done");
      go(16'h3300);
      chk(probe_status_word, 16'h0100);
      ev(3, 1'b1, 32'h0000_5555);
      ev(3, 1'b0, 32'h0000_5555);
      chk(probe_status_word, 16'h0100);
      ev(2, 1'b1, 32'h0000_6666);
      chk(p2_pos_rise, 32'h0000_6666);
      ev(2, 1'b0, 32'h0000_7777);
      chk(p2_pos_fall, 32'h0000_7777);
      chk(probe_status_word, 16'h0700);
      ev(2, 1'b1, 32'h0000_8888);
      chk(p2_pos_rise, 32'h0000_8888);
      ev(2, 1'b0, 32'h0000_9999);
      chk(p2_pos_fall, 32'h0000_9999);
      $display("test probe 2 continuous done");
      go(16'h1700);
      ev(2, 1'b1, 32'h0000_AAAA);
      ev(2, 1'b0, 32'h0000_AAAA);
      chk(probe_status_word, 16'h0100);
      ev(3, 1'b1, 32'h0000_BBBB);
      chk(p2_pos_rise, 32'h0000_BBBB);
      ev(3, 1'b0, 32'h0000_CCCC);
      chk(probe_status_word, 16'h0300);
      chk(p2_pos_fall, 32'h0000_9999);
      $display("test zero pulse source done");
      go(16'h2100);
      ev(2, 1'b1, 32'h0000_DDDD);
      chk(probe_status_word, 16'h0100);
      ev(2, 1'b0, 32'h0000_EEEE);
      chk(probe_status_word, 16'h0500);
      chk(p2_pos_fall, 32'h0000_EEEE);
      $display("test edge enables done");
      go(16'h0017);
      ev(3, 1'b1, 32'h0000_1234);
      chk(p1_pos_rise, 32'h0000_1234);
      ev(3, 1'b0, 32'h0000_4321);
      ev(3, 1'b1, 32'h0000_5678);
      chk(p1_pos_rise, 32'h0000_5678);
      chk(probe_status_word, 16'h0003);
      chk(p1_pos_fall, 32'h0000_2222);
      ev(3, 1'b0, 32'h0000_4321);
      $display("test probe 1 zero pulse continuous done");
      go(16'hC9C9);
      chk(probe_status_word, 16'h0101);
      go(16'h0000);
      chk(probe_status_word, 16'h0000);
      chk(p2_pos_fall, 32'h0000_EEEE);
      $display("test reserved and stop done");
      summarize();
   end
endmodule

// file: verilog/tpls_channel.sv
// One touch probe channel: start control, edge detection and position latches.
`timescale 1ns/1ps
module tpls_channel
   import tpls_pkg::*;
#(
   parameter int POS_W = 32
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire tpls_cfg_t cfg,
   input wire logic trig_ext,
   input wire logic trig_zero,
   input wire logic [POS_W-1:0] position,
   output tpls_stat_t stat,
   output logic [POS_W-1:0] pos_rise,
   output logic [POS_W-1:0] pos_fall
);

   // ==========================================================================
   // Start control
   // ==========================================================================
   tpls_state_t state_q;
   tpls_cfg_t cfg_q;
   logic exec_prev_q;
   logic trig_prev_q;
   logic rise_armed_q;
   logic fall_armed_q;
   logic start;
   logic trig;
   logic rise_ev;
   logic fall_ev;
   logic live;

   assign start = cfg.exec && !exec_prev_q;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         exec_prev_q <= 1'b0;
      end else begin
         exec_prev_q <= cfg.exec;
      end
   end

   // Settings are frozen at start so edits while running take no effect.
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state_q <= TPLS_IDLE;
         cfg_q <= '0;
      end else if (!cfg.exec) begin
         state_q <= TPLS_IDLE;
      end else if (start) begin
         state_q <= TPLS_ARMED;
         cfg_q <= cfg;
      end
   end

   // ==========================================================================
   // Trigger source and edge detection
   // ==========================================================================
   always_comb begin
      case (state_q)
         TPLS_ARMED: trig = cfg_q.src_zero ? trig_zero : trig_ext;
         TPLS_IDLE: trig = trig_ext;
         default: trig = trig_ext;
      endcase
   end

   // The previous level is reloaded at start so a level already active then
   // does not count as an edge.
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         trig_prev_q <= 1'b0;
      end else if (start) begin
         trig_prev_q <= cfg.src_zero ? trig_zero : trig_ext;
      end else begin
         trig_prev_q <= trig;
      end
   end

   // An edge in the cycle in which execute drops is refused, so that a position
   // is never latched while its stored flag is being cleared.
   assign live = (state_q == TPLS_ARMED) && cfg.exec && !start;
   assign rise_ev = live && trig && !trig_prev_q;
   assign fall_ev = live && !trig && trig_prev_q;

   // ==========================================================================
   // Arming, latching and stored flags
   // ==========================================================================
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         rise_armed_q <= 1'b0;
         fall_armed_q <= 1'b0;
      end else if (!cfg.exec) begin
         rise_armed_q <= 1'b0;
         fall_armed_q <= 1'b0;
      end else if (start) begin
         rise_armed_q <= cfg.rise_en;
         fall_armed_q <= cfg.fall_en;
      end else begin
         if (rise_ev && !cfg_q.cont) begin
            rise_armed_q <= 1'b0;
         end
         if (fall_ev && !cfg_q.cont) begin
            fall_armed_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         pos_rise <= TPLS_POS_RESET;
         pos_fall <= TPLS_POS_RESET;
      end else begin
         if (rise_ev && rise_armed_q) begin
            pos_rise <= position;
         end
         if (fall_ev && fall_armed_q) begin
            pos_fall <= position;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         stat <= '0;
      end else if (!cfg.exec || start) begin
         stat <= '0;
      end else begin
         stat.running <= 1'b1;
         if (rise_ev && rise_armed_q) begin
            stat.rise_stored <= 1'b1;
         end
         if (fall_ev && fall_armed_q) begin
            stat.fall_stored <= 1'b1;
         end
      end
   end

endmodule

// file: verilog/tpls_pkg.sv
// Shared constants and carrier types for the touch probe latch and status block.
package tpls_pkg;

   // ==========================================================================
   // Object addresses
   // ==========================================================================
   localparam logic [15:0] TPLS_FUNC_INDEX = 16'h60B8;
   localparam logic [15:0] TPLS_STATUS_INDEX = 16'h60B9;

   // ==========================================================================
   // Probe function word fields (probe 1 low byte, probe 2 high byte)
   // ==========================================================================
   localparam int TPLS_P1_BASE = 0;
   localparam int TPLS_P2_BASE = 8;
   localparam int TPLS_F_EXEC = 0;
   localparam int TPLS_F_CONT = 1;
   localparam int TPLS_F_SRC = 2;
   localparam int TPLS_F_RISE = 4;
   localparam int TPLS_F_FALL = 5;

   // ==========================================================================
   // Probe status word fields and reset value
   // ==========================================================================
   localparam int TPLS_S_RUN = 0;
   localparam int TPLS_S_RISE = 1;
   localparam int TPLS_S_FALL = 2;
   localparam logic [15:0] TPLS_STATUS_RESET = 16'h0000;
   localparam logic [31:0] TPLS_POS_RESET = 32'h0000_0000;

   // Settings of one probe as taken from its byte of the function word.
   typedef struct packed {
      logic fall_en;
      logic rise_en;
      logic src_zero;
      logic cont;
      logic exec;
   } tpls_cfg_t;

   // State of one probe as shown in its byte of the status word.
   typedef struct packed {
      logic fall_stored;
      logic rise_stored;
      logic running;
   } tpls_stat_t;

   typedef enum logic [1:0] {
      TPLS_IDLE = 2'b01,
      TPLS_ARMED = 2'b10
   } tpls_state_t;

endpackage

// file: verilog/tpls_top.sv
// Touch probe latch unit: pin synchronisers, two probe channels, status word.
// Notes on behaviour
// - Probe 2 source 1 uses encoder zero pulse.
// - Bit 12 enables probe 2 rising latch.
// - Bit 13 enables probe 2 falling latch.
// - Edges follow logical state, not polarity.
// - Read-only 16-bit status word for both probes.
// - Status bit 0 shows probe 1 running.
// - Status bit 1 shows probe 1 rising stored.
// - Status bit 2 shows probe 1 falling stored.
// - Status bit 8 shows probe 2 running.
// - Status bit 9 shows probe 2 rising stored.
// - Status bit 10 shows probe 2 falling stored.
// - Probe 2 source 0 uses external input.
// - Start and settings capture on execute rise.
// - Single mode latches first trigger only.
// - Continuous mode latches every valid trigger.
`timescale 1ns/1ps
module tpls_top
   import tpls_pkg::*;
#(
   parameter int POS_W = 32
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [15:0] probe_function_word,
   input wire logic probe1_in,
   input wire logic probe2_in,
   input wire logic enc_zero_in,
   input wire logic [POS_W-1:0] position,
   output logic [15:0] probe_status_word,
   output logic [POS_W-1:0] p1_pos_rise,
   output logic [POS_W-1:0] p1_pos_fall,
   output logic [POS_W-1:0] p2_pos_rise,
   output logic [POS_W-1:0] p2_pos_fall
);

   // ==========================================================================
   // Pin synchronisers
   // ==========================================================================
   // Probe pins and the zero pulse are asynchronous, so each passes two
   // flip-flops; only the second stage is read.
   logic [2:0] pin_meta_q;
   logic [2:0] pin_sync_q;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         pin_meta_q <= 3'h0;
         pin_sync_q <= 3'h0;
      end else begin
         pin_meta_q <= {enc_zero_in, probe2_in, probe1_in};
         pin_sync_q <= pin_meta_q;
      end
   end

   // ==========================================================================
   // Function word decode
   // ==========================================================================
   tpls_cfg_t cfg1;
   tpls_cfg_t cfg2;
   tpls_stat_t stat1;
   tpls_stat_t stat2;

   // Only the documented bits are picked out; bits 3, 6, 7, 11, 14 and 15
   // go nowhere.
   always_comb begin
      cfg1.exec = probe_function_word[TPLS_P1_BASE + TPLS_F_EXEC];
      cfg1.cont = probe_function_word[TPLS_P1_BASE + TPLS_F_CONT];
      cfg1.src_zero = probe_function_word[TPLS_P1_BASE + TPLS_F_SRC];
      cfg1.rise_en = probe_function_word[TPLS_P1_BASE + TPLS_F_RISE];
      cfg1.fall_en = probe_function_word[TPLS_P1_BASE + TPLS_F_FALL];
      cfg2.exec = probe_function_word[TPLS_P2_BASE + TPLS_F_EXEC];
      cfg2.cont = probe_function_word[TPLS_P2_BASE + TPLS_F_CONT];
      cfg2.src_zero = probe_function_word[TPLS_P2_BASE + TPLS_F_SRC];
      cfg2.rise_en = probe_function_word[TPLS_P2_BASE + TPLS_F_RISE];
      cfg2.fall_en = probe_function_word[TPLS_P2_BASE + TPLS_F_FALL];
   end

   // ==========================================================================
   // Probe channels
   // ==========================================================================
   tpls_channel #(
      .POS_W(POS_W)
   ) u_probe1 (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .cfg(cfg1),
      .trig_ext(pin_sync_q[0]),
      .trig_zero(pin_sync_q[2]),
      .position(position),
      .stat(stat1),
      .pos_rise(p1_pos_rise),
      .pos_fall(p1_pos_fall)
   );

   tpls_channel #(
      .POS_W(POS_W)
   ) u_probe2 (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .cfg(cfg2),
      .trig_ext(pin_sync_q[1]),
      .trig_zero(pin_sync_q[2]),
      .position(position),
      .stat(stat2),
      .pos_rise(p2_pos_rise),
      .pos_fall(p2_pos_fall)
   );

   // ==========================================================================
   // Status word
   // ==========================================================================
   logic [15:0] status_d;

   always_comb begin
      status_d = TPLS_STATUS_RESET;
      status_d[TPLS_P1_BASE + TPLS_S_RUN] = stat1.running;
      status_d[TPLS_P1_BASE + TPLS_S_RISE] = stat1.rise_stored;
      status_d[TPLS_P1_BASE + TPLS_S_FALL] = stat1.fall_stored;
      status_d[TPLS_P2_BASE + TPLS_S_RUN] = stat2.running;
      status_d[TPLS_P2_BASE + TPLS_S_RISE] = stat2.rise_stored;
      status_d[TPLS_P2_BASE + TPLS_S_FALL] = stat2.fall_stored;
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         probe_status_word <= TPLS_STATUS_RESET;
      end else begin
         probe_status_word <= status_d;
      end
   end

endmodule
